// file: hdl/efu_pkg.sv
// Purpose: Shared constants and types of the earth-fault, unbalance and breaker failure logic.
// Assumes: 50 MHz hclk; currents are unsigned codes with the rated current at I_RATED.
// Notes:   Register offsets are byte addresses on the AHB-Lite slave.
package efu_pkg;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int CLK_MHZ    = 50;
  localparam int TICK_US    = 1000;
  localparam int TICK_CYC   = TICK_US * CLK_MHZ;
  localparam int BF_MAX_MS  = 110;
  localparam logic [15:0] BF_MAX_TICKS = 16'(BF_MAX_MS * 1000 / TICK_US);

  // ******************************************************
  // Measurement scaling
  // ******************************************************
  localparam logic [15:0] I_RATED  = 16'h03e8;
  localparam logic [15:0] I_DISC_MIN = 16'(I_RATED / 10);

  // ******************************************************
  // Register offsets
  // ******************************************************
  localparam logic [7:0] A_CURVE  = 8'h00;
  localparam logic [7:0] A_EXTSG  = 8'h04;
  localparam logic [7:0] A_LATBF  = 8'h08;
  localparam logic [7:0] A_INDSEL = 8'h0c;
  localparam logic [7:0] A_THR_LO = 8'h10;
  localparam logic [7:0] A_THR_HI = 8'h14;
  localparam logic [7:0] A_DPCT   = 8'h18;
  localparam logic [7:0] A_T_LO   = 8'h1c;
  localparam logic [7:0] A_T_HI   = 8'h20;
  localparam logic [7:0] A_T_DC   = 8'h24;
  localparam logic [7:0] A_T_BF   = 8'h28;
  localparam logic [7:0] A_MAT_S  = 8'h2c;
  localparam logic [7:0] A_MAT_T  = 8'h30;
  localparam logic [7:0] A_STAT   = 8'h34;
  localparam logic [7:0] A_IRQ_ST = 8'h38;
  localparam logic [7:0] A_IRQ_MK = 8'h3c;
  localparam logic [7:0] A_CMD    = 8'h40;

  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int F_INV     = 0;
  localparam int F_CURVE   = 1;
  localparam int F_INVINH  = 4;
  localparam int F_HI_EN   = 5;
  localparam int F_DC_EN   = 6;
  localparam int F_BLK_LO  = 0;
  localparam int F_BLK_HI  = 3;
  localparam int F_BLK_DC  = 6;
  localparam int F_RST_C   = 7;
  localparam int F_BF_EN   = 4;

  // ******************************************************
  // Reset values
  // ******************************************************
  localparam logic [7:0]  RST_CURVE = 8'h60;
  localparam logic [15:0] RST_THR   = 16'hffff;
  localparam logic [7:0]  RST_DPCT  = 8'h64;
  localparam logic [15:0] RST_TIME  = 16'h0064;

  // ******************************************************
  // Display codes
  // ******************************************************
  localparam logic [3:0] C_NONE  = 4'h0;
  localparam logic [3:0] C_LO_S  = 4'h1;
  localparam logic [3:0] C_HI_S  = 4'h2;
  localparam logic [3:0] C_DC_S  = 4'h3;
  localparam logic [3:0] C_LO_OP = 4'h4;
  localparam logic [3:0] C_HI_OP = 4'h5;
  localparam logic [3:0] C_DC_OP = 4'h6;
  localparam logic [3:0] C_BF_OP = 4'h7;

  // ******************************************************
  // Carriers
  // ******************************************************
  typedef struct packed {
    logic [15:0] neutral;
    logic [15:0] l1;
    logic [15:0] l2;
    logic [15:0] l3;
  } efu_meas_t;

  typedef struct packed {
    logic [3:0] start_outputs;
    logic [3:0] trip_outputs;
    logic       trip_led;
    logic [3:0] disp_code;
  } efu_out_t;

endpackage

// file: hdl/efu_top.sv
// Purpose: Neutral overcurrent, phase unbalance and breaker failure decision logic.
// Assumes: Measurements come from same-clock logic; block pins are asynchronous.
// Notes:   Timers run on a 1 ms enable pulse from a divider on hclk.
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Each neutral stage starts while neutral current exceeds its threshold.
// - A started neutral stage operates after its definite or inverse time.
// - Selected external block inputs inhibit the neutral stages.
// - Low neutral stage runs definite or one of six inverse curves.
// - High neutral stage can be disabled; then it never starts or operates.
// - Optionally low stage inverse timing yields to high stage timing.
// - Any stage start shows a numeric code on the display output.
// - Unbalance stage is idle when phase currents are below 0.1 rated.
// - Unbalance stage starts when percentage exceeds its setting.
// - Persistent unbalance operates and shows a red operation code.
// - Unbalance stage can be disabled and blocked by input a.
// - Breaker failure asserts trip output 1 within 0.11 s if fault persists.
// - Breaker failure is enabled per source trip output; its delay is settable.
// - Matrix routes any stage start or operate to any start or trip output.
// - Each trip output can latch until a reset.
module efu_top #(
  parameter int TICK_CYCLES = efu_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Measurements and block pins
  input  wire efu_pkg::efu_meas_t meas,
  input  wire logic              ext_block_in_a,
  input  wire logic              ext_block_in_b,
  input  wire logic              ext_block_reset_in_c,
  // Relay outputs and interrupt
  output efu_pkg::efu_out_t      outs,
  output logic                   irq
);
  import efu_pkg::*;

  typedef struct packed {
    logic [2:0]  sy1;
    logic [2:0]  sy2;
    logic [15:0] div;
    logic [15:0] tl;
    logic [15:0] th;
    logic [15:0] td;
    logic [15:0] tb;
    logic [31:0] acc;
    logic        lo_s;
    logic        hi_s;
    logic        dc_s;
    logic [3:0]  latch;
    logic        led;
    logic [3:0]  code;
    logic [3:0]  ss;
    logic [3:0]  ts;
    logic [7:0]  sg_curve;
    logic [7:0]  sg_ext;
    logic [7:0]  sg_latbf;
    logic [7:0]  sg_ind;
    logic [15:0] thr_lo;
    logic [15:0] thr_hi;
    logic [7:0]  dpct;
    logic [15:0] t_lo;
    logic [15:0] t_hi;
    logic [15:0] t_dc;
    logic [15:0] t_bf;
    logic [23:0] mat_s;
    logic [23:0] mat_t;
    logic [3:0]  irq_st;
    logic [3:0]  irq_mk;
    logic        wr_pend;
    logic [7:0]  waddr;
    logic [31:0] rdata;
  } efu_state_t;

  efu_state_t st_reg;
  efu_state_t st_next;

  // ******************************************************
  // Helpers
  // ******************************************************
  function automatic logic [15:0] max3(input logic [15:0] a, b, c);
    logic [15:0] m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction

  function automatic logic [15:0] min3(input logic [15:0] a, b, c);
    logic [15:0] m;
    m = (a < b) ? a : b;
    return (m < c) ? m : c;
  endfunction

  // Unbalance percent; guarded against a zero maximum.
  function automatic logic [7:0] unbal_pct(input logic [15:0] mx, mn);
    logic [23:0] num;
    num = 24'(mx - mn) * 24'd100;
    return (mx == 16'h0000) ? 8'h00 : 8'(num / 24'(mx));
  endfunction

  // Timer step: saturating count on the tick, zero when not started.
  function automatic logic [15:0] tstep(input logic run, tick, input logic [15:0] t);
    if (!run) return 16'h0000;
    if (tick && t != 16'hffff) return t + 16'h0001;
    return t;
  endfunction

  // Stage signals s: 0 lo start, 1 lo op, 2 hi start, 3 hi op, 4 dc start, 5 dc op.
  function automatic logic [3:0] route(input logic [5:0] s, input logic [23:0] m);
    logic [3:0] o;
    o = 4'h0;
    for (int i = 0; i < 6; i++) begin
      if (s[i]) o = o | m[4*i +: 4];
    end
    return o;
  endfunction

  logic [15:0] imax;
  logic [15:0] imin;
  logic [7:0]  upct;
  logic [2:0]  blk;
  logic        tick;
  logic        lo_s;
  logic        hi_s;
  logic        dc_s;
  logic        lo_op;
  logic        hi_op;
  logic        dc_op;
  logic        bf_op;
  logic        inv;
  logic        unlatch;
  logic [15:0] excess;
  logic [2:0]  curve;
  logic [5:0]  sig;
  logic [3:0]  ts_raw;
  logic [3:0]  ss_new;
  logic [3:0]  ts_new;
  logic [3:0]  ev;
  logic        rd_ok;
  logic        wr_ok;
  logic [31:0] rd_val;
  logic [15:0] bf_lim;

  // ******************************************************
  // Next state
  // ******************************************************
  always_comb begin
    st_next = st_reg;
    // Block pins are asynchronous; only the second stage is read.
    st_next.sy1 = {ext_block_reset_in_c, ext_block_in_b, ext_block_in_a};
    st_next.sy2 = st_reg.sy1;
    blk = st_reg.sy2;

    tick = (st_reg.div == 16'(TICK_CYCLES - 1));
    st_next.div = tick ? 16'h0000 : st_reg.div + 16'h0001;

    // Neutral stages.
    lo_s = (meas.neutral > st_reg.thr_lo)
         && ((blk & st_reg.sg_ext[F_BLK_LO +: 3]) == 3'b000);
    hi_s = st_reg.sg_curve[F_HI_EN] && (meas.neutral > st_reg.thr_hi)
         && ((blk & st_reg.sg_ext[F_BLK_HI +: 3]) == 3'b000);

    // Unbalance stage.
    imax = max3(meas.l1, meas.l2, meas.l3);
    imin = min3(meas.l1, meas.l2, meas.l3);
    upct = unbal_pct(imax, imin);
    dc_s = st_reg.sg_curve[F_DC_EN] && (imax >= I_DISC_MIN)
         && !(blk[0] && st_reg.sg_ext[F_BLK_DC])
         && (upct > st_reg.dpct);

    // Timers restart on a rising start and clear when it drops.
    st_next.lo_s = lo_s;
    st_next.hi_s = hi_s;
    st_next.dc_s = dc_s;
    st_next.tl = tstep(lo_s && st_reg.lo_s, tick, st_reg.tl);
    st_next.th = tstep(hi_s && st_reg.hi_s, tick, st_reg.th);
    st_next.td = tstep(dc_s && st_reg.dc_s, tick, st_reg.td);

    // Inverse time: per-tick integral of excess current, steeper curves weigh more.
    inv = st_reg.sg_curve[F_INV];
    curve = st_reg.sg_curve[F_CURVE +: 3];
    excess = meas.neutral - st_reg.thr_lo;
    if (!(lo_s && st_reg.lo_s)) begin
      st_next.acc = 32'h0;
    end else if (tick && st_reg.acc[31] == 1'b0) begin
      st_next.acc = st_reg.acc + (32'(excess) << ((curve > 3'd5) ? 3'd5 : curve));
    end

    hi_op = hi_s && st_reg.hi_s && (st_reg.th >= st_reg.t_hi);
    if (inv && st_reg.sg_curve[F_INVINH] && hi_s) begin
      lo_op = hi_op;
    end else if (inv) begin
      lo_op = lo_s && st_reg.lo_s && (st_reg.acc >= {8'h00, st_reg.t_lo, 8'h00});
    end else begin
      lo_op = lo_s && st_reg.lo_s && (st_reg.tl >= st_reg.t_lo);
    end
    dc_op = dc_s && st_reg.dc_s && (st_reg.td >= st_reg.t_dc);

    // Output matrix.
    sig = {dc_op, dc_s, hi_op, hi_s, lo_op, lo_s};
    ss_new = route(sig, st_reg.mat_s);
    ts_raw = route(sig, st_reg.mat_t);

    // Breaker failure: enabled sources among trip outputs 2..4, fault still present.
    bf_lim = (st_reg.t_bf > BF_MAX_TICKS) ? BF_MAX_TICKS : st_reg.t_bf;
    st_next.tb = tstep(((st_reg.ts[3:1] & st_reg.sg_latbf[F_BF_EN +: 3]) != 3'b000)
                       && (lo_s || hi_s || dc_s), tick, st_reg.tb);
    bf_op = (st_reg.tb != 16'h0000) && (st_reg.tb >= bf_lim);
    ts_raw[0] = ts_raw[0] | bf_op;

    unlatch = 1'b0;
    if (blk[2] && st_reg.sg_ext[F_RST_C]) unlatch = 1'b1;
    if (st_reg.wr_pend && st_reg.waddr == A_CMD && hwdata[0]) unlatch = 1'b1;

    ts_new = ts_raw | (st_reg.ts & st_reg.latch);
    if (unlatch) ts_new = ts_raw;
    st_next.ts = ts_new;
    st_next.ss = ss_new;
    st_next.latch = st_reg.sg_latbf[3:0];

    if (unlatch) begin
      st_next.led = 1'b0;
    end
    if (({ts_new, ss_new} & st_reg.sg_ind) != 8'h00) st_next.led = 1'b1;

    // Display code: operate codes outrank start codes and hold until cleared.
    if (bf_op) st_next.code = C_BF_OP;
    else if (dc_op) st_next.code = C_DC_OP;
    else if (hi_op) st_next.code = C_HI_OP;
    else if (lo_op) st_next.code = C_LO_OP;
    else if (st_reg.code >= C_LO_OP && !unlatch) st_next.code = st_reg.code;
    else if (hi_s) st_next.code = C_HI_S;
    else if (lo_s) st_next.code = C_LO_S;
    else if (dc_s) st_next.code = C_DC_S;
    else st_next.code = C_NONE;

    // ******************************************************
    // AHB-Lite slave, zero wait states
    // ******************************************************
    ev = {bf_op, dc_op, hi_op, lo_op};
    rd_ok = hsel && hready && htrans[1] && !hwrite;
    wr_ok = hsel && hready && htrans[1] && hwrite;
    st_next.wr_pend = wr_ok && (haddr[31:8] == 24'h0);
    st_next.waddr = haddr[7:0];

    if (haddr[7:0] == A_CURVE) rd_val = {24'h0, st_reg.sg_curve};
    else if (haddr[7:0] == A_EXTSG) rd_val = {24'h0, st_reg.sg_ext};
    else if (haddr[7:0] == A_LATBF) rd_val = {24'h0, st_reg.sg_latbf};
    else if (haddr[7:0] == A_INDSEL) rd_val = {24'h0, st_reg.sg_ind};
    else if (haddr[7:0] == A_THR_LO) rd_val = {16'h0, st_reg.thr_lo};
    else if (haddr[7:0] == A_THR_HI) rd_val = {16'h0, st_reg.thr_hi};
    else if (haddr[7:0] == A_DPCT) rd_val = {24'h0, st_reg.dpct};
    else if (haddr[7:0] == A_T_LO) rd_val = {16'h0, st_reg.t_lo};
    else if (haddr[7:0] == A_T_HI) rd_val = {16'h0, st_reg.t_hi};
    else if (haddr[7:0] == A_T_DC) rd_val = {16'h0, st_reg.t_dc};
    else if (haddr[7:0] == A_T_BF) rd_val = {16'h0, st_reg.t_bf};
    else if (haddr[7:0] == A_MAT_S) rd_val = {8'h0, st_reg.mat_s};
    else if (haddr[7:0] == A_MAT_T) rd_val = {8'h0, st_reg.mat_t};
    else if (haddr[7:0] == A_STAT) rd_val = {8'h0, upct, st_reg.code, st_reg.led,
                                            st_reg.dc_s, st_reg.hi_s, st_reg.lo_s,
                                            st_reg.ts, st_reg.ss};
    else if (haddr[7:0] == A_IRQ_ST) rd_val = {28'h0, st_reg.irq_st};
    else if (haddr[7:0] == A_IRQ_MK) rd_val = {28'h0, st_reg.irq_mk};
    else rd_val = 32'h0;
    st_next.rdata = (rd_ok && haddr[31:8] == 24'h0) ? rd_val : 32'h0;

    // Data phase writes; unmapped addresses are ignored.
    if (st_reg.wr_pend) begin
      if (st_reg.waddr == A_CURVE) st_next.sg_curve = hwdata[7:0];
      else if (st_reg.waddr == A_EXTSG) st_next.sg_ext = hwdata[7:0];
      else if (st_reg.waddr == A_LATBF) st_next.sg_latbf = hwdata[7:0];
      else if (st_reg.waddr == A_INDSEL) st_next.sg_ind = hwdata[7:0];
      else if (st_reg.waddr == A_THR_LO) st_next.thr_lo = hwdata[15:0];
      else if (st_reg.waddr == A_THR_HI) st_next.thr_hi = hwdata[15:0];
      else if (st_reg.waddr == A_DPCT) st_next.dpct = hwdata[7:0];
      else if (st_reg.waddr == A_T_LO) st_next.t_lo = hwdata[15:0];
      else if (st_reg.waddr == A_T_HI) st_next.t_hi = hwdata[15:0];
      else if (st_reg.waddr == A_T_DC) st_next.t_dc = hwdata[15:0];
      else if (st_reg.waddr == A_T_BF) st_next.t_bf = hwdata[15:0];
      else if (st_reg.waddr == A_MAT_S) st_next.mat_s = hwdata[23:0];
      else if (st_reg.waddr == A_MAT_T) st_next.mat_t = hwdata[23:0];
      else if (st_reg.waddr == A_IRQ_MK) st_next.irq_mk = hwdata[3:0];
    end

    // Write one clears, but a new event in the same cycle wins.
    st_next.irq_st = st_reg.irq_st;
    if (st_reg.wr_pend && st_reg.waddr == A_IRQ_ST) begin
      st_next.irq_st = st_reg.irq_st & ~hwdata[3:0];
    end
    st_next.irq_st = st_next.irq_st | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.sg_curve <= RST_CURVE;
      st_reg.thr_lo <= RST_THR;
      st_reg.thr_hi <= RST_THR;
      st_reg.dpct <= RST_DPCT;
      st_reg.t_lo <= RST_TIME;
      st_reg.t_hi <= RST_TIME;
      st_reg.t_dc <= RST_TIME;
      st_reg.t_bf <= RST_TIME;
    end else begin
      st_reg <= st_next;
    end
  end

  // ******************************************************
  // Outputs
  // ******************************************************
  assign hrdata = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign outs.start_outputs = st_reg.ss;
  assign outs.trip_outputs = st_reg.ts;
  assign outs.trip_led = st_reg.led;
  assign outs.disp_code = st_reg.code;
  assign irq = (st_reg.irq_st & st_reg.irq_mk) != 4'h0;

endmodule // efu_top

`default_nettype wire

// file: verif/efu_top_checker.sv
// Purpose: Port-level assertions for the neutral, unbalance and breaker failure logic.
// Assumes: Register writes are tracked by snooping the AHB-Lite data phase.
// Notes:   Only the registers that the properties need are interpreted.
`timescale 1ns/1ps
`default_nettype none
module efu_top_checker
  import efu_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // Bus
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic              hready,
  input wire logic [31:0]       hwdata,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // Pins and outputs
  input wire efu_meas_t         meas,
  input wire logic              ext_block_in_a,
  input wire logic              ext_block_in_b,
  input wire logic              ext_block_reset_in_c,
  input wire efu_out_t          outs,
  input wire logic              irq
);
  // ******************************************************
  // Register shadow
  // ******************************************************
  logic        wr_dp;
  logic [7:0]  dp_a;
  logic [31:0] sh [0:16];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp <= 1'b0;
      dp_a  <= 8'h00;
      for (int i = 0; i < 17; i++) sh[i] <= 32'h0;
      sh[0] <= 32'h60;
      sh[4] <= 32'hffff;
    end else begin
      wr_dp <= hsel && hready && htrans[1] && hwrite && (haddr[31:8] == 24'h0);
      dp_a  <= haddr[7:0];
      if (wr_dp && dp_a[7:2] < 6'd17) sh[dp_a[7:2]] <= hwdata;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ******************************************************
  // Properties
  // ******************************************************
  lo_route_a: assert property ((meas.neutral > sh[4][15:0] && sh[11][0] && !ext_block_in_a && !ext_block_in_b
    && !ext_block_reset_in_c) [*3] |-> ##[0:2] outs.start_outputs[0]) else $error("low stage start not routed");
  block_a_a: assert property ((ext_block_in_a && sh[1][0] && (sh[11] & 32'h111111) == 32'h1) [*4]
    |-> ##[0:2] !outs.start_outputs[0]) else $error("blocked low stage still starts");
  hi_off_a: assert property (!sh[0][5] [*3] |-> outs.disp_code != C_HI_S) else $error("disabled high stage started");
  start_code_a: assert property (outs.start_outputs != 4'h0 |-> ##[0:2] outs.disp_code != C_NONE)
    else $error("start without display code");
  dc_idle_a: assert property ((meas.l1 < I_DISC_MIN && meas.l2 < I_DISC_MIN && meas.l3 < I_DISC_MIN) [*4]
    |-> outs.disp_code != C_DC_S) else $error("unbalance active at low current");
  latch_hold_a: assert property ((outs.trip_outputs[1] && sh[2][1] && !ext_block_reset_in_c) [*3] ##0 !wr_dp
    |=> outs.trip_outputs[1]) else $error("latched trip output dropped");
  led_hold_a: assert property ($fell(outs.trip_led) |-> $past(wr_dp && dp_a == A_CMD && hwdata[0]) || sh[1][7])
    else $error("trip indicator cleared without reset");
  bf_source_a: assert property ($rose(outs.trip_outputs[0]) |-> ((sh[12] & 32'h111111) != 32'h0)
    || (($past(outs.trip_outputs[3:1]) & sh[2][6:4]) != 3'h0)) else $error("trip output 1 without source");
endmodule // efu_top_checker
bind efu_top efu_top_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .meas(meas), .ext_block_in_a(ext_block_in_a),
  .ext_block_in_b(ext_block_in_b), .ext_block_reset_in_c(ext_block_reset_in_c), .outs(outs), .irq(irq));
`default_nettype wire

// file: verif/efu_relay_model.sv
// Purpose: Breaker with trip coils that opens once any coil is energized long enough.
// Assumes: The bench removes the fault current while the breaker is open.
// Notes:   A stuck breaker never opens, which is what makes breaker failure back-up needed.
`timescale 1ns/1ps
`default_nettype none
module efu_relay_model #(
  parameter int OPEN_CYC = 3
) (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Coils and state
  input wire logic [3:0] coils,
  input wire logic       stuck,
  output logic           open
);
  int cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt <= 0;
    else cnt <= (coils != 4'h0 && !stuck) ? cnt + 1 : 0;
  end
  assign open = cnt >= OPEN_CYC;
endmodule // efu_relay_model
`default_nettype wire

// file: verif/earth_fault_unbalance_breaker_failure_backup_logic_bench.sv
// Purpose: Self-checking bench for the neutral, unbalance and breaker failure logic.
// Assumes: One tick is four clock cycles so that operate times stay short.
// Notes:   Start routing is table driven; timing, latching and reset are hand tests.
`timescale 1ns/1ps
`default_nettype none
module earth_fault_unbalance_breaker_failure_backup_logic_bench;
  import efu_pkg::*;
  localparam int TK = 4;
  typedef struct packed {
    logic [7:0] cv, ex; logic [1:0] pin; logic [15:0] n, l1, l2, l3; logic [3:0] ss;
  } efu_row_t;
  efu_row_t rows [12] = '{
    '{8'h60,8'h00,2'h0,16'h065,16'h0,16'h0,16'h0,4'h1}, '{8'h60,8'h00,2'h0,16'h064,16'h0,16'h0,16'h0,4'h0},
    '{8'h60,8'h00,2'h0,16'h201,16'h0,16'h0,16'h0,4'h3}, '{8'h40,8'h00,2'h0,16'h201,16'h0,16'h0,16'h0,4'h1},
    '{8'h60,8'h01,2'h1,16'h201,16'h0,16'h0,16'h0,4'h2}, '{8'h60,8'h08,2'h1,16'h201,16'h0,16'h0,16'h0,4'h1},
    '{8'h60,8'h00,2'h0,16'h0,16'h3e8,16'h3e8,16'h2bc,4'h4}, '{8'h60,8'h00,2'h0,16'h0,16'h3e8,16'h3e8,16'h320,4'h0},
    '{8'h60,8'h00,2'h0,16'h0,16'h063,16'h063,16'h000,4'h0}, '{8'h60,8'h40,2'h1,16'h0,16'h3e8,16'h3e8,16'h2bc,4'h0},
    '{8'h20,8'h00,2'h0,16'h0,16'h3e8,16'h3e8,16'h2bc,4'h0}, '{8'h60,8'h10,2'h2,16'h201,16'h0,16'h0,16'h0,4'h1}};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pa = 1'b0, pb = 1'b0, pc = 1'b0, stuck = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  wire         hrdy, hresp, brk_open;
  efu_meas_t   meas = '0;
  efu_out_t    outs;
  logic        irq;
  int          failures = 0, tests_run = 0, n;
  always #10 hclk = ~hclk;
  efu_top #(.TICK_CYCLES(TK)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hrdy), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy),
    .hresp(hresp), .meas(meas), .ext_block_in_a(pa), .ext_block_in_b(pb), .ext_block_reset_in_c(pc),
    .outs(outs), .irq(irq));
  efu_relay_model i_brk (.hclk(hclk), .hresetn(hresetn), .coils(outs.trip_outputs), .stuck(stuck), .open(brk_open));
  // An open breaker interrupts the neutral fault current.
  always @(posedge hclk) if (brk_open === 1'b1) meas.neutral <= 16'h0;
  // ******************************************************
  // Tasks
  // ******************************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hrdy !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, r);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_trip(input int b, input int lim);
    n = 0;
    while (outs.trip_outputs[b] !== 1'b1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    give_verdict;
  end
  // ******************************************************
  // Sequence
  // ******************************************************
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    wr(A_THR_LO, 32'h64); wr(A_THR_HI, 32'h200); wr(A_DPCT, 32'h14); wr(A_MAT_S, 32'h40201);
    foreach (rows[i]) begin
      wr(A_CURVE, {24'h0, rows[i].cv}); wr(A_EXTSG, {24'h0, rows[i].ex});
      {pb, pa} <= rows[i].pin;
      meas <= '{rows[i].n, rows[i].l1, rows[i].l2, rows[i].l3};
      repeat (6) @(posedge hclk);
      chk("start_outputs", {28'h0, outs.start_outputs}, {28'h0, rows[i].ss});
    end
    {pb, pa} <= 2'h0;
    meas <= '0;
    $display("routing table done");
    wr(A_T_LO, 32'h5); wr(A_MAT_T, 32'h20); wr(A_LATBF, 32'h2); wr(A_INDSEL, 32'h20); wr(A_IRQ_MK, 32'h1);
    wr(A_CURVE, 32'h40);
    meas <= '{16'h100, 16'h0, 16'h0, 16'h0};
    repeat (3 * TK) @(posedge hclk);
    meas.neutral <= 16'h0;
    repeat (4) @(posedge hclk);
    chk("early_trip", {31'h0, outs.trip_outputs[1]}, 32'h0);
    meas.neutral <= 16'h100;
    wait_trip(1, 200);
    chk("op_delay", {31'h0, n >= 4 * TK && n <= 6 * TK + 4}, 32'h1);
    chk("op_code", {28'h0, outs.disp_code}, {28'h0, C_LO_OP});
    chk("irq_set", {31'h0, irq}, 32'h1);
    meas.neutral <= 16'h0;
    repeat (8) @(posedge hclk);
    chk("trip_latched", {31'h0, outs.trip_outputs[1]}, 32'h1);
    chk("led_held", {31'h0, outs.trip_led}, 32'h1);
    wr(A_IRQ_ST, 32'h1); @(posedge hclk);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    wr(A_CMD, 32'h1); repeat (2) @(posedge hclk);
    chk("unlatched", {27'h0, outs.trip_outputs, outs.trip_led}, 32'h0);
    $display("timing and latching done");
    wr(A_IRQ_MK, 32'h0); wr(A_LATBF, 32'h10); wr(A_T_BF, 32'hc8);
    meas.neutral <= 16'h100;
    wait_trip(0, 600);
    chk("bf_cleared_fault", {31'h0, n < 600}, 32'h0);
    stuck <= 1'b1; meas.neutral <= 16'h100;
    wait_trip(1, 100); wait_trip(0, 600);
    chk("bf_delay", {31'h0, n <= 111 * TK}, 32'h1);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    bus(1'b0, A_IRQ_ST, 32'h0, r);
    chk("bf_status", {31'h0, r[3]}, 32'h1);
    meas.neutral <= 16'h0; wr(A_CMD, 32'h1);
    $display("breaker failure done");
    wr(A_T_DC, 32'h3); wr(A_MAT_T, 32'h800000);
    meas <= '{16'h0, 16'h3e8, 16'h3e8, 16'h2bc};
    wait_trip(3, 60);
    chk("dc_op_code", {27'h0, outs.trip_outputs[3], outs.disp_code}, {27'h0, 1'b1, C_DC_OP});
    // Curve 3 steepens the inverse integral, so it must trip well before the definite time would.
    wr(A_MAT_T, 32'h20); wr(A_CURVE, 32'h47);
    meas <= '{16'h100, 16'h0, 16'h0, 16'h0};
    wait_trip(1, 60);
    chk("inverse_op", {31'h0, n <= 4 * TK}, 32'h1);
    meas <= '0;
    $display("unbalance operate done");
    hresetn <= 1'b0; repeat (2) @(posedge hclk);
    chk("outs_in_reset", {19'h0, outs}, 32'h0);
    hresetn <= 1'b1; @(posedge hclk);
    bus(1'b0, A_CURVE, 32'h0, r); chk("curve_rst", r, 32'h60);
    bus(1'b0, A_THR_LO, 32'h0, r); chk("thr_rst", r, 32'hffff);
    bus(1'b0, A_DPCT, 32'h0, r); chk("dpct_rst", r, 32'h64);
    bus(1'b0, A_T_BF, 32'h0, r); chk("tbf_rst", r, 32'h64);
    wr(A_STAT, 32'hffffffff); bus(1'b0, A_STAT, 32'h0, r); chk("stat_ro", r, 32'h0);
    wr(8'h44, 32'hffffffff); bus(1'b0, 8'h44, 32'h0, r); chk("unmapped", r, 32'h0);
    chk("okay_resp", {31'h0, hresp}, 32'h0);
    $display("reset and registers done");
    give_verdict;
  end
endmodule // earth_fault_unbalance_breaker_failure_backup_logic_bench
`default_nettype wire
